// ===== rtl/mbx_exec.sv
// Execute unit for multiply, jump, call, return, compare, skip and branch operations
`timescale 1ns/1ps
module mbx_exec #(
  parameter int PC_W = 22
) (
  input  wire logic                    ref_clk,
  input  wire logic                    reset,
  input  wire logic                    start,
  input  mbx_pkg::mbx_op_t             op,
  input  wire logic [7:0]              reg_d,
  input  wire logic [7:0]              reg_r,
  input  wire logic [7:0]              imm,
  input  wire logic [2:0]              bit_sel,
  input  wire logic [7:0]              io_byte,
  input  wire logic                    next_two_word,
  input  wire logic [PC_W-1:0]         pc_in,
  input  wire logic [15:0]             z_ptr,
  input  wire logic [7:0]              ext_ind,
  input  wire logic [7:0]              status_register_in,
  input  wire logic [PC_W-1:0]         stack_pc,
  input  wire logic [PC_W-1:0]         target,
  input  wire logic [11:0]             offset,
  output logic                         ready,
  output logic                         busy,
  output logic                         done,
  output logic      [PC_W-1:0]         pc_out,
  output logic                         pc_we,
  output logic      [15:0]             prod_out,
  output logic                         prod_we,
  output logic      [7:0]              status_register_out,
  output logic                         status_register_we,
  output logic      [PC_W-1:0]         push_addr,
  output logic                         push_we,
  output logic                         pop_req
);

  if (PC_W < mbx_pkg::PTR_W || PC_W > mbx_pkg::PTR_W + 8) begin : g_bad_pc_w
    $error("mbx_exec: PC_W must lie between 16 and 24");
  end

  typedef struct packed {
    mbx_pkg::mbx_state_t st;
    logic [2:0]          cnt;
    logic [PC_W-1:0]     pc;
    logic [15:0]         prod;
    logic [7:0]          status_register;
    logic [PC_W-1:0]     ret;
    logic                pc_we;
    logic                prod_we;
    logic                status_register_we;
    logic                push;
    logic                pop;
  } mbx_regs_t;

  mbx_regs_t s_r;
  mbx_regs_t s_nxt;

  logic            take;
  logic [15:0]     mul_prod;
  logic            mul_c;
  logic            mul_a_s;
  logic            mul_b_s;
  logic            mul_frac;
  logic [7:0]      cmp_b;
  logic            cmp_cin;
  logic [7:0]      diff;
  logic [7:0]      cmp_flags;
  logic [PC_W-1:0] off_ext;
  logic [PC_W-1:0] rel_pc;
  logic [PC_W-1:0] ext_pc;
  logic [PC_W-1:0] z_pc;
  logic            skip_cond;
  logic            skip_op;
  logic            br_cond;
  logic            br_op;
  logic [1:0]      skip_step;
  logic [2:0]      skip_cyc;

  assign busy  = s_r.st == mbx_pkg::st_run;
  assign done  = busy && s_r.cnt == 3'h0;
  assign ready = !busy || done;
  assign take  = start && ready;

  assign pc_out    = s_r.pc;
  assign prod_out  = s_r.prod;
  assign status_register_out  = s_r.status_register;
  assign push_addr = s_r.ret;
  assign pc_we     = done && s_r.pc_we;
  assign prod_we   = done && s_r.prod_we;
  assign status_register_we   = done && s_r.status_register_we;
  assign push_we   = done && s_r.push;
  assign pop_req   = done && s_r.pop;

  // Multiplier operand modes
  assign mul_a_s  = op == mbx_pkg::op_mixed_sign_multiply ||
                    op == mbx_pkg::op_fractional_multiply_signed ||
                    op == mbx_pkg::op_fractional_multiply_mixed;
  assign mul_b_s  = op == mbx_pkg::op_fractional_multiply_signed;
  assign mul_frac = op != mbx_pkg::op_mixed_sign_multiply;

  mbx_multiplier #(.W(8)) u_mul (
    .a        (reg_d),
    .b        (reg_r),
    .a_signed (mul_a_s),
    .b_signed (mul_b_s),
    .frac     (mul_frac),
    .product  (mul_prod),
    .carry    (mul_c)
  );

  // Compare: difference with borrow flags, no register written
  assign cmp_b   = (op == mbx_pkg::op_compare_immediate) ? imm : reg_r;
  assign cmp_cin = (op == mbx_pkg::op_compare_with_carry) & status_register_in[mbx_pkg::SR_C];
  assign diff    = reg_d - cmp_b - {7'h00, cmp_cin};

  always_comb begin
    cmp_flags = status_register_in;
    cmp_flags[mbx_pkg::SR_H] = (~reg_d[3] & cmp_b[3]) | (cmp_b[3] & diff[3]) |
                               (diff[3] & ~reg_d[3]);
    cmp_flags[mbx_pkg::SR_C] = (~reg_d[7] & cmp_b[7]) | (cmp_b[7] & diff[7]) |
                               (diff[7] & ~reg_d[7]);
    cmp_flags[mbx_pkg::SR_V] = (reg_d[7] & ~cmp_b[7] & ~diff[7]) |
                               (~reg_d[7] & cmp_b[7] & diff[7]);
    cmp_flags[mbx_pkg::SR_N] = diff[7];
    // Carry form keeps Z only while the chain stays zero
    cmp_flags[mbx_pkg::SR_Z] = (diff == 8'h00) &
                               (op != mbx_pkg::op_compare_with_carry | status_register_in[mbx_pkg::SR_Z]);
  end

  // Targets
  assign off_ext = {{(PC_W-mbx_pkg::OFF_W){offset[11]}}, offset};
  assign rel_pc  = pc_in + off_ext + PC_W'(mbx_pkg::STEP_NEXT);
  assign z_pc    = PC_W'(z_ptr);
  assign ext_pc  = PC_W'({ext_ind, z_ptr});

  // Skip and branch conditions
  always_comb begin
    skip_op   = 1'b1;
    skip_cond = 1'b0;
    unique case (op)
      mbx_pkg::op_compare_skip_equal: skip_cond = reg_d == reg_r;
      mbx_pkg::op_skip_reg_bit_clear: skip_cond = !reg_r[bit_sel];
      mbx_pkg::op_skip_reg_bit_set:   skip_cond = reg_r[bit_sel];
      mbx_pkg::op_skip_io_bit_clear:  skip_cond = !io_byte[bit_sel];
      mbx_pkg::op_skip_io_bit_set:    skip_cond = io_byte[bit_sel];
      default:                        skip_op   = 1'b0;
    endcase
    br_op   = 1'b1;
    br_cond = 1'b0;
    unique case (op)
      mbx_pkg::op_branch_flag_set:     br_cond = status_register_in[bit_sel];
      mbx_pkg::op_branch_flag_clear:   br_cond = !status_register_in[bit_sel];
      mbx_pkg::op_branch_on_equal:     br_cond = status_register_in[mbx_pkg::SR_Z];
      mbx_pkg::op_branch_on_not_equal: br_cond = !status_register_in[mbx_pkg::SR_Z];
      default:                         br_op   = 1'b0;
    endcase
  end

  // Skip length follows the next instruction's word count
  assign skip_step = !skip_cond ? mbx_pkg::STEP_NEXT :
                     next_two_word ? mbx_pkg::STEP_SKIP_TWO : mbx_pkg::STEP_SKIP_ONE;
  assign skip_cyc  = !skip_cond ? mbx_pkg::CYC_NOT_TAKEN :
                     next_two_word ? mbx_pkg::CYC_SKIP_TWO : mbx_pkg::CYC_SKIP_ONE;

  always_comb begin
    s_nxt = s_r;
    if (s_r.st == mbx_pkg::st_run) begin
      if (done) s_nxt.st = mbx_pkg::st_idle;
      else s_nxt.cnt = s_r.cnt - 3'h1;
    end
    if (take) begin
      s_nxt.st      = mbx_pkg::st_run;
      s_nxt.pc_we   = 1'b1;
      s_nxt.prod_we = 1'b0;
      s_nxt.status_register_we = 1'b0;
      s_nxt.push    = 1'b0;
      s_nxt.pop     = 1'b0;
      s_nxt.pc      = pc_in + PC_W'(mbx_pkg::STEP_NEXT);
      s_nxt.ret     = pc_in + PC_W'(mbx_pkg::STEP_NEXT);
      s_nxt.cnt     = mbx_pkg::CYC_CMP - 3'h1;
      if (skip_op) begin
        s_nxt.pc  = pc_in + PC_W'(skip_step);
        s_nxt.cnt = skip_cyc - 3'h1;
      end else if (br_op) begin
        s_nxt.pc  = br_cond ? rel_pc : pc_in + PC_W'(mbx_pkg::STEP_NEXT);
        s_nxt.cnt = (br_cond ? mbx_pkg::CYC_BR_TAKEN : mbx_pkg::CYC_NOT_TAKEN) - 3'h1;
      end else begin
        unique case (op)
          mbx_pkg::op_mixed_sign_multiply, mbx_pkg::op_fractional_multiply_unsigned,
          mbx_pkg::op_fractional_multiply_signed, mbx_pkg::op_fractional_multiply_mixed: begin
            s_nxt.prod    = mul_prod;
            s_nxt.prod_we = 1'b1;
            s_nxt.status_register_we = 1'b1;
            s_nxt.status_register    = status_register_in;
            s_nxt.status_register[mbx_pkg::SR_C] = mul_c;
            s_nxt.status_register[mbx_pkg::SR_Z] = mul_prod == 16'h0000;
            s_nxt.cnt     = mbx_pkg::CYC_MUL - 3'h1;
          end
          mbx_pkg::op_relative_jump: begin
            s_nxt.pc  = rel_pc;
            s_nxt.cnt = mbx_pkg::CYC_JMP_SHORT - 3'h1;
          end
          mbx_pkg::op_indirect_jump: begin
            s_nxt.pc  = z_pc;
            s_nxt.cnt = mbx_pkg::CYC_JMP_SHORT - 3'h1;
          end
          mbx_pkg::op_extended_indirect_jump: begin
            s_nxt.pc  = ext_pc;
            s_nxt.cnt = mbx_pkg::CYC_JMP_SHORT - 3'h1;
          end
          mbx_pkg::op_direct_jump: begin
            s_nxt.pc  = target;
            s_nxt.cnt = mbx_pkg::CYC_JMP_DIR - 3'h1;
          end
          mbx_pkg::op_relative_call, mbx_pkg::op_indirect_call,
          mbx_pkg::op_extended_indirect_call: begin
            s_nxt.push = 1'b1;
            s_nxt.cnt  = mbx_pkg::CYC_CALL - 3'h1;
            if (op == mbx_pkg::op_relative_call) s_nxt.pc = rel_pc;
            else if (op == mbx_pkg::op_indirect_call) s_nxt.pc = z_pc;
            else s_nxt.pc = ext_pc;
          end
          mbx_pkg::op_direct_call: begin
            s_nxt.push = 1'b1;
            s_nxt.pc   = target;
            s_nxt.ret  = pc_in + PC_W'(mbx_pkg::STEP_SKIP_ONE);
            s_nxt.cnt  = mbx_pkg::CYC_CALL_DIR - 3'h1;
          end
          mbx_pkg::op_subroutine_return, mbx_pkg::op_interrupt_return: begin
            s_nxt.pop = 1'b1;
            s_nxt.pc  = stack_pc;
            s_nxt.cnt = mbx_pkg::CYC_RET - 3'h1;
            if (op == mbx_pkg::op_interrupt_return) begin
              s_nxt.status_register    = status_register_in;
              s_nxt.status_register[mbx_pkg::SR_I] = 1'b1;
              s_nxt.status_register_we = 1'b1;
            end
          end
          mbx_pkg::op_register_compare, mbx_pkg::op_compare_with_carry,
          mbx_pkg::op_compare_immediate: begin
            s_nxt.status_register    = cmp_flags;
            s_nxt.status_register_we = 1'b1;
            s_nxt.cnt     = mbx_pkg::CYC_CMP - 3'h1;
          end
          default: s_nxt.pc_we = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      s_r <= '{st: mbx_pkg::st_idle, cnt: 3'h0, pc: '0, prod: mbx_pkg::PROD_RST,
               status_register: mbx_pkg::STATUS_REGISTER_RST, ret: '0, pc_we: 1'b0, prod_we: 1'b0,
               status_register_we: 1'b0, push: 1'b0, pop: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // Checks
  AST_MIXED_MUL: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_mixed_sign_multiply |=> !done ##1 (done && prod_we && status_register_we))
    else $error("mixed multiply not done in 2 cycles");
  AST_FRAC_MUL: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_fractional_multiply_unsigned |-> ##2 (done && !prod_out[0]))
    else $error("fractional product not shifted or late");
  AST_IND_JUMP: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_indirect_jump |-> ##2 (done && pc_out == PC_W'($past(z_ptr, 2))))
    else $error("indirect jump target or timing wrong");
  AST_DIR_JUMP: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_direct_jump |=> !done [*2] ##1 done)
    else $error("direct jump not 3 cycles");
  AST_EXT_JUMP: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_extended_indirect_jump |-> ##2 (done && !status_register_we &&
      pc_out == PC_W'({$past(ext_ind, 2), $past(z_ptr, 2)})))
    else $error("extended jump wrong");
  AST_CALL_DIR: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_direct_call |-> ##5 (done && push_we && !status_register_we &&
      push_addr == $past(pc_in, 5) + PC_W'(2)))
    else $error("direct call wrong");
  AST_EXT_CALL: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_extended_indirect_call |-> ##4 (done && push_we && !status_register_we))
    else $error("extended call not 4 cycles");
  AST_COMPARE_SKIP_EQUAL_SKIP: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_compare_skip_equal && reg_d == reg_r && !next_two_word
      |-> ##2 (done && pc_out == $past(pc_in, 2) + PC_W'(2)))
    else $error("equal compare skip wrong");
  AST_COMPARE: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_register_compare |=> (done && status_register_we && !prod_we &&
      status_register_out[mbx_pkg::SR_Z] == ($past(reg_d) == $past(reg_r))))
    else $error("compare flags or timing wrong");
  AST_SKIP_NOT_TAKEN: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_skip_reg_bit_clear && reg_r[bit_sel]
      |=> (done && pc_out == $past(pc_in) + PC_W'(1)))
    else $error("untaken skip wrong");
  AST_SKIP_TWO: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_skip_io_bit_set && io_byte[bit_sel] && next_two_word
      |-> ##3 (done && pc_out == $past(pc_in, 3) + PC_W'(3)))
    else $error("two-word skip wrong");
  AST_BRANCH_TAKEN: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_branch_flag_set && status_register_in[bit_sel] |=> !done ##1 done)
    else $error("taken branch not 2 cycles");
  AST_BRANCH_NE: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_branch_on_not_equal && status_register_in[mbx_pkg::SR_Z]
      |=> (done && pc_out == $past(pc_in) + PC_W'(1)))
    else $error("untaken branch wrong");
  AST_INTERRUPT_RETURN: assert property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_interrupt_return |-> ##5 (done && pop_req && status_register_we &&
      status_register_out[mbx_pkg::SR_I]))
    else $error("interrupt return wrong");

  COV_MUL: cover property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_fractional_multiply_mixed);
  COV_CALL: cover property (@(posedge ref_clk) disable iff (reset)
    take && op == mbx_pkg::op_relative_call ##4 done);
  COV_SKIP: cover property (@(posedge ref_clk) disable iff (reset)
    take && skip_op && skip_cond && next_two_word);
  COV_BACK: cover property (@(posedge ref_clk) disable iff (reset) done && take);

endmodule // mbx_exec

// ===== rtl/mbx_pkg.sv
// Shared operation codes, cycle counts and status bit positions for the execute unit
package mbx_pkg;

  typedef enum logic [4:0] {
    op_mixed_sign_multiply,
    op_fractional_multiply_unsigned,
    op_fractional_multiply_signed,
    op_fractional_multiply_mixed,
    op_relative_jump,
    op_indirect_jump,
    op_extended_indirect_jump,
    op_direct_jump,
    op_relative_call,
    op_indirect_call,
    op_extended_indirect_call,
    op_direct_call,
    op_subroutine_return,
    op_interrupt_return,
    op_compare_skip_equal,
    op_register_compare,
    op_compare_with_carry,
    op_compare_immediate,
    op_skip_reg_bit_clear,
    op_skip_reg_bit_set,
    op_skip_io_bit_clear,
    op_skip_io_bit_set,
    op_branch_flag_set,
    op_branch_flag_clear,
    op_branch_on_equal,
    op_branch_on_not_equal
  } mbx_op_t;

  typedef enum logic {
    st_idle,
    st_run
  } mbx_state_t;

  // Cycle counts
  localparam logic [2:0] CYC_MUL       = 3'h2;
  localparam logic [2:0] CYC_JMP_SHORT = 3'h2;
  localparam logic [2:0] CYC_JMP_DIR   = 3'h3;
  localparam logic [2:0] CYC_CALL      = 3'h4;
  localparam logic [2:0] CYC_CALL_DIR  = 3'h5;
  localparam logic [2:0] CYC_RET       = 3'h5;
  localparam logic [2:0] CYC_CMP       = 3'h1;
  localparam logic [2:0] CYC_NOT_TAKEN = 3'h1;
  localparam logic [2:0] CYC_BR_TAKEN  = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE  = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO  = 3'h3;

  // Program counter steps in words
  localparam logic [1:0] STEP_NEXT     = 2'h1;
  localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
  localparam logic [1:0] STEP_SKIP_TWO = 2'h3;

  // Status register bit positions
  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 3;
  localparam int SR_H = 5;
  localparam int SR_I = 7;

  localparam logic [7:0]  STATUS_REGISTER_RST = 8'h00;
  localparam logic [15:0] PROD_RST = 16'h0000;
  localparam int          OFF_W    = 12;
  localparam int          PTR_W    = 16;

endpackage

// ===== rtl/mbx_multiplier.sv
// Signed, unsigned and fractional 8 by 8 multiplier
`timescale 1ns/1ps
module mbx_multiplier #(
  parameter int W = 8
) (
  input  wire logic [W-1:0]   a,
  input  wire logic [W-1:0]   b,
  input  wire logic           a_signed,
  input  wire logic           b_signed,
  input  wire logic           frac,
  output logic      [2*W-1:0] product,
  output logic                carry
);

  if (W < 2) begin : g_bad_width
    $error("mbx_multiplier: W must be at least 2");
  end

  logic signed [W:0]     a_ext;
  logic signed [W:0]     b_ext;
  logic signed [2*W+1:0] raw;

  assign a_ext = $signed({a_signed & a[W-1], a});
  assign b_ext = $signed({b_signed & b[W-1], b});
  assign raw   = a_ext * b_ext;
  // Carry is taken from the unshifted product
  assign carry   = raw[2*W-1];
  assign product = frac ? {raw[2*W-2:0], 1'b0} : raw[2*W-1:0];

endmodule // mbx_multiplier

// ===== test/mbx_exec_tb.sv
// Self-checking bench for the execute unit against a behavioural model
`timescale 1ns/1ps
module test_mbx_exec;
  localparam int PC_W = 22;
  logic              ref_clk = 1'b0;
  logic              reset = 1'b1;
  logic              start = 1'b0;
  logic              next_two_word = 1'b0;
  mbx_pkg::mbx_op_t  op = mbx_pkg::op_register_compare;
  logic [7:0]        reg_d = 8'h00, reg_r = 8'h00, imm = 8'h00, io_byte = 8'h00;
  logic [7:0]        ext_ind = 8'h00, status_register_in = 8'h00;
  logic [2:0]        bit_sel = 3'h0;
  logic [PC_W-1:0]   pc_in = '0, stack_pc = '0, target = '0;
  logic [15:0]       z_ptr = 16'h0000;
  logic [11:0]       offset = 12'h000;
  logic              ready, busy, done, pc_we, prod_we, status_register_we, push_we, pop_req;
  logic [PC_W-1:0]   pc_out, push_addr;
  logic [15:0]       prod_out;
  logic [7:0]        status_register_out;
  int                fail_count = 0;
  int                comparisons = 0;
  int                e_cyc;
  logic [PC_W-1:0]   e_pc, e_push, brt;
  logic [15:0]       e_prod;
  logic [7:0]        e_sr;
  logic [4:0]        e_en;

  mbx_exec #(.PC_W(PC_W)) uut (
    .ref_clk(ref_clk), .reset(reset), .start(start), .op(op), .reg_d(reg_d),
    .reg_r(reg_r), .imm(imm), .bit_sel(bit_sel), .io_byte(io_byte),
    .next_two_word(next_two_word), .pc_in(pc_in), .z_ptr(z_ptr), .ext_ind(ext_ind),
    .status_register_in(status_register_in), .stack_pc(stack_pc), .target(target), .offset(offset),
    .ready(ready), .busy(busy), .done(done), .pc_out(pc_out), .pc_we(pc_we),
    .prod_out(prod_out), .prod_we(prod_we), .status_register_out(status_register_out), .status_register_we(status_register_we),
    .push_addr(push_addr), .push_we(push_we), .pop_req(pop_req));

  always #4 ref_clk = ~ref_clk;

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask

  task automatic rnd();
    logic [31:0] r1, r2, r3;
    r1 = $urandom; r2 = $urandom; r3 = $urandom;
    reg_d <= r1[7:0]; reg_r <= r3[31] ? r1[7:0] : r1[15:8]; imm <= r1[23:16];
    io_byte <= r1[31:24]; bit_sel <= r3[2:0]; next_two_word <= r3[3];
    status_register_in <= r3[11:4]; ext_ind <= r3[19:12]; offset <= r3[30:19];
    pc_in <= r2[21:0]; z_ptr <= r2[31:16]; stack_pc <= {r2[5:0], r3[15:0]};
    target <= {r1[5:0], r2[15:0]};
  endtask

  // Expected outcome; enables are {pc, prod, status_register, push, pop}
  task automatic model(input int k);
    int a, b, p, dd, ss, cin, r;
    logic cond;
    e_pc = pc_in + 1'b1; e_cyc = 1; e_en = 5'b10000; e_sr = status_register_in; e_prod = '0;
    e_push = pc_in + 1'b1; cond = 1'b0;
    brt = pc_in + {{10{offset[11]}}, offset} + 1'b1;
    case (k)
      0, 1, 2, 3: begin
        a = (k == 1) ? int'(reg_d) : int'($signed(reg_d));
        b = (k == 2) ? int'($signed(reg_r)) : int'(reg_r);
        p = a * b;
        e_prod = (k == 0) ? p[15:0] : {p[14:0], 1'b0};
        e_sr[0] = p[15]; e_sr[1] = (e_prod == 16'h0000); e_cyc = 2; e_en = 5'b11100;
      end
      4: begin e_pc = brt; e_cyc = 2; end
      5: begin e_pc = PC_W'(z_ptr); e_cyc = 2; end
      6: begin e_pc = PC_W'({ext_ind, z_ptr}); e_cyc = 2; end
      7: begin e_pc = target; e_cyc = 3; end
      8, 9, 10, 11: begin
        e_pc = (k == 8) ? brt : (k == 9) ? PC_W'(z_ptr) :
               (k == 10) ? PC_W'({ext_ind, z_ptr}) : target;
        e_cyc = (k == 11) ? 5 : 4; e_en = 5'b10010;
        e_push = (k == 11) ? pc_in + 2'h2 : pc_in + 1'b1;
      end
      12, 13: begin
        e_pc = stack_pc; e_cyc = 5; e_en = (k == 13) ? 5'b10101 : 5'b10001; e_sr[7] = 1'b1;
      end
      15, 16, 17: begin
        dd = reg_d; ss = (k == 17) ? imm : reg_r; cin = (k == 16) ? status_register_in[0] : 0;
        r = dd - ss - cin;
        e_sr[0] = (r < 0); e_sr[5] = (((dd & 15) - (ss & 15) - cin) < 0);
        e_sr[1] = (r[7:0] == 8'h00) && (k != 16 || status_register_in[1]); e_sr[2] = r[7];
        e_sr[3] = (dd[7] & !ss[7] & !r[7]) | (!dd[7] & ss[7] & r[7]); e_en = 5'b10100;
      end
      14: cond = (reg_d == reg_r);
      18: cond = !reg_r[bit_sel];
      19: cond = reg_r[bit_sel];
      20: cond = !io_byte[bit_sel];
      21: cond = io_byte[bit_sel];
      22: if (status_register_in[bit_sel]) begin e_pc = brt; e_cyc = 2; end
      23: if (!status_register_in[bit_sel]) begin e_pc = brt; e_cyc = 2; end
      24: if (status_register_in[1]) begin e_pc = brt; e_cyc = 2; end
      25: if (!status_register_in[1]) begin e_pc = brt; e_cyc = 2; end
      default: ;
    endcase
    if (cond) begin
      e_cyc = next_two_word ? 3 : 2;
      e_pc = pc_in + PC_W'(e_cyc);
    end
  endtask

  // One operation; with refuse set, start stays up with new garbage while busy
  task automatic run_op(input int k, input bit refuse);
    int n;
    @(posedge ref_clk);
    rnd();
    start <= 1'b1;
    op <= mbx_pkg::mbx_op_t'(k[4:0]);
    @(posedge ref_clk);
    model(k);
    start <= refuse && e_cyc > 1;
    if (refuse) rnd();
    for (n = 1; n < 9; n++) begin
      @(negedge ref_clk);
      if (done === 1'b1) break;
      chk("ready while busy", 32'h0, ready);
      @(posedge ref_clk);
      if (n + 1 == e_cyc) start <= 1'b0;
    end
    chk("cycles", e_cyc, n);
    chk("pc_out", e_pc, pc_out);
    chk("enables", e_en, {pc_we, prod_we, status_register_we, push_we, pop_req});
    if (e_en[3]) chk("prod_out", e_prod, prod_out);
    if (e_en[2]) chk("status_register_out", e_sr, status_register_out);
    if (e_en[1]) chk("push_addr", e_push, push_addr);
  endtask

  initial begin
    #100000;
    fail_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(94));
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("busy in reset", 32'h0, busy);
    chk("ready in reset", 32'h1, ready);
    chk("pc_out in reset", 32'h0, pc_out);
    @(posedge ref_clk);
    reset <= 1'b0;
    $display("reset test done");
    for (int i = 0; i < 12; i++) begin
      for (int k = 0; k < 28; k++) run_op(k, i[0]);
    end
    $display("operation sweep done");
    @(posedge ref_clk);
    start <= 1'b1;
    op <= mbx_pkg::op_direct_call;
    @(posedge ref_clk);
    start <= 1'b0;
    @(posedge ref_clk);
    reset <= 1'b1;
    @(negedge ref_clk);
    chk("busy after abort", 32'h0, busy);
    chk("enables after abort", 32'h0, {pc_we, push_we, done});
    @(posedge ref_clk);
    reset <= 1'b0;
    run_op(11, 1'b0);
    $display("mid-run reset test done");
    report_and_stop();
  end
endmodule // test_mbx_exec
